// ---- logic/rie_consts.svh ----
`ifndef RIE_CONSTS_SVH
`define RIE_CONSTS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define RIE_OFS_CTRL      10'h000
`define RIE_OFS_INSTR     10'h004
`define RIE_OFS_STATUS    10'h008
`define RIE_OFS_ACC       10'h00c
`define RIE_OFS_PMADDR    10'h010
`define RIE_OFS_PMDATA    10'h014
`define RIE_OFS_ID0       10'h020
`define RIE_OFS_ID3       10'h02c
`define RIE_FILE_SEL      3'h1
`define RIE_RD_ZERO       32'h0000_0000

// ****************************************
// Field positions
// ****************************************
`define RIE_CTRL_PROG     0
`define RIE_CTRL_WAKE     1
`define RIE_ST_C          0
`define RIE_ST_DC         1
`define RIE_ST_Z          2

// ****************************************
// Reset values
// ****************************************
`define RIE_ACC_RST       8'h00
`define RIE_FLAG_RST      1'b0
`define RIE_TO_RST        1'b1
`define RIE_PD_RST        1'b1
`define RIE_PIN_CHANGE_WAKE_FLAG_RST     1'b1
`define RIE_INSTR_RST     12'h000
`define RIE_PMADDR_RST    9'h000
`define RIE_ID_RST        12'hfff

// ****************************************
// Opcode patterns
// ****************************************
`define RIE_OP_ADD        6'h07
`define RIE_OP_AND_ACC_REG      6'h05
`define RIE_OP_SUB        6'h02
`define RIE_OP_AND_LITERAL_ACC      4'he
`define RIE_OP_BCF        4'h4
`define RIE_OP_SLEEP      12'h003
`define RIE_PCL_ADDR      5'h02

// ****************************************
// Timing: last phase of a one- and two-cycle instruction, and commit phase
// ****************************************
`define RIE_PH_LAST1      3'h3
`define RIE_PH_LAST2      3'h7
`define RIE_PH_COMMIT     3'h1

`endif

// ---- logic/rie_pkg.sv ----
// ****************************************
// Shared types
// ****************************************
package rie_pkg;
    // Execution state
    typedef enum logic [1:0] {
        RIE_ST_IDLE  = 2'b00,
        RIE_ST_EXEC  = 2'b01,
        RIE_ST_SLEEP = 2'b10
    } rie_state_t;
endpackage : rie_pkg

// ---- logic/rie_rf_if.sv ----
`timescale 1ns/1ps
// ****************************************
// File register port bundle
// ****************************************
interface rie_rf_if;
    logic [4:0] raddr;  // Read index
    logic [7:0] rdata;  // Registered read data
    logic       we;     // Write strobe
    logic [4:0] waddr;  // Write index
    logic [7:0] wdata;  // Write data
    modport core (output raddr, we, waddr, wdata, input rdata);
    modport mem  (input raddr, we, waddr, wdata, output rdata);
endinterface : rie_rf_if

// ---- logic/rie_file_mem.sv ----
`timescale 1ns/1ps
// ****************************************
// 32 x 8 file register array
// ****************************************
module rie_file_mem
(
    // Clock
    input wire logic core_clk_in,
    // Array port
    rie_rf_if.mem    rf
);
    logic [7:0] mem [0:31];  // Storage, no reset like real RAM

    // Read before write (old data at the written address), read data always registered
    always_ff @(posedge core_clk_in)
    begin
        if (rf.we)
        begin
            mem[rf.waddr] <= rf.wdata;
        end
        rf.rdata <= mem[rf.raddr];
    end
endmodule : rie_file_mem

// ---- logic/rie_core.sv ----
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rie_consts.svh"
// Overview of operation
// (RULE1) Decode each instruction as one 12-bit word
// (RULE2) Destination bit: 0 accumulator, 1 file
// (RULE3) File field selects one of 32 registers
// (RULE4) Bit field selects bit 0..7
// (RULE5) Literal field is 8 or 9 bits
// (RULE6) Don't-care encoding bits are ignored
// (RULE7) One instruction cycle is four clocks
// (RULE8) PC change stretches to two cycles
// (RULE9) Add accumulator and file, update C DC Z
// (RULE10) AND literal into accumulator, Z only
// (RULE11) AND accumulator with file, Z only
// (RULE12) Bit clear, no flags changed
// (RULE13) Sleep clears watchdog, sets flags, halts
// (RULE14) Subtract accumulator from file, C DC Z
// (RULE15) Unprotected program memory readable for verify
// (RULE16) Four ID words, only in program mode
// (RULE17) Programmer keeps ID upper bits ones
// (RULE18) Subtract carry is inverted borrow
// (RULE19) Zero flag set on all-zero result
module rie_core
    import rie_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Program memory verify path
    input  wire logic [11:0] pm_data_in,
    input  wire logic        code_protect_in,
    output logic      [8:0]  pm_addr_out,
    // Watchdog and power state
    output logic             wdt_clear_out,
    output logic             sleep_out
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Eight-bit add with carry in, carry out on top
    function automatic logic [8:0] rie_add9(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci);
        rie_add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : rie_add9

    // Carry out of the low nibble
    function automatic logic rie_nib_carry(input logic [3:0] a, input logic [3:0] b,
                                           input logic ci);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
        rie_nib_carry = s[4];
    endfunction : rie_nib_carry

    // ****************************************
    // State
    // ****************************************
    rie_state_t  state_q;          // Execution state
    rie_state_t  state_d;          // Next execution state
    logic [2:0]  ph_q;             // Clock within instruction
    logic        two_q;            // Instruction takes two cycles
    logic [11:0] instr_q;          // Instruction being run
    logic [7:0]  acc_q;            // Accumulator
    logic        c_q;              // Carry
    logic        dc_q;             // Half carry
    logic        z_q;              // Zero
    logic        to_q;             // Timeout flag
    logic        pd_q;             // Power-down flag
    logic        pin_change_wake_flag_q;          // Pin-change wake flag
    logic        prog_q;           // Program/verify mode
    logic [8:0]  pm_addr_q;        // Verify address
    logic [11:0] id_q [0:3];       // ID words
    logic        wait_q;           // Waitrequest, high until answer
    logic [31:0] rdata_q;          // Read data
    logic        frd_q;            // File read data is valid
    logic        wdt_clr_q;        // Watchdog clear pulse
    logic        sleep_q;          // Sleeping

    rie_rf_if rf ();

    // File registers live in their own array
    rie_file_mem i_rie_file_mem
    (
        .core_clk_in (core_clk_in),
        .rf          (rf)
    );

    // ****************************************
    // Instruction field decode
    // ****************************************
    wire [4:0] f_fld  = instr_q[4:0];             // RULE3
    wire       d_bit  = instr_q[5];               // RULE2
    wire [2:0] b_fld  = instr_q[7:5];             // RULE4
    wire [7:0] lit8   = instr_q[7:0];             // RULE5
    // Only the opcode bits are compared; x positions never reach a compare
    wire op_add   = instr_q[11:6] == `RIE_OP_ADD;    // RULE1 RULE6
    wire op_and_acc_reg = instr_q[11:6] == `RIE_OP_AND_ACC_REG;  // RULE1 RULE6
    wire op_sub   = instr_q[11:6] == `RIE_OP_SUB;    // RULE1 RULE6
    wire op_and_literal_acc = instr_q[11:8] == `RIE_OP_AND_LITERAL_ACC;  // RULE1 RULE6
    wire op_bcf   = instr_q[11:8] == `RIE_OP_BCF;    // RULE1 RULE6
    wire op_sleep = instr_q == `RIE_OP_SLEEP;        // RULE1
    wire op_byte  = op_add | op_and_acc_reg | op_sub;

    // ****************************************
    // Datapath
    // ****************************************
    wire [7:0] fval    = rf.rdata;                           // Operand from file
    wire [8:0] add_sum = rie_add9(acc_q, fval, 1'b0);        // RULE9
    wire [8:0] sub_sum = rie_add9(fval, ~acc_q, 1'b1);       // RULE14
    wire       add_dc  = rie_nib_carry(acc_q[3:0], fval[3:0], 1'b0);  // RULE9
    wire       sub_dc  = rie_nib_carry(fval[3:0], ~acc_q[3:0], 1'b1); // RULE14
    wire [7:0] bmask   = 8'h01 << b_fld;                     // RULE4

    // Result select
    wire [7:0] res = op_add   ? add_sum[7:0] :               // RULE9
                     op_sub   ? sub_sum[7:0] :               // RULE14
                     op_and_acc_reg ? (acc_q & fval) :             // RULE11
                     op_and_literal_acc ? (acc_q & lit8) :             // RULE10
                     op_bcf   ? (fval & ~bmask) :            // RULE12
                     8'h00;

    // Where the result goes and which flags move
    wire to_file  = (op_byte & d_bit) | op_bcf;              // RULE2 RULE12
    wire to_acc   = (op_byte & ~d_bit) | op_and_literal_acc;           // RULE2 RULE10
    wire sets_z   = op_byte | op_and_literal_acc;                      // RULE10 RULE11
    wire sets_c   = op_add | op_sub;                         // RULE9 RULE14
    wire new_c    = op_add ? add_sum[8] : sub_sum[8];        // RULE18
    wire new_dc   = op_add ? add_dc : sub_dc;
    wire new_z    = res == 8'h00;                            // RULE19
    // Writing the program counter low byte costs a second cycle
    wire pc_write = to_file & (f_fld == `RIE_PCL_ADDR);      // RULE8

    // Phase control
    wire commit   = (state_q == RIE_ST_EXEC) & (ph_q == `RIE_PH_COMMIT);
    wire [2:0] ph_last = two_q ? `RIE_PH_LAST2 : `RIE_PH_LAST1;   // RULE7 RULE8
    wire ph_end   = (state_q == RIE_ST_EXEC) & (ph_q == ph_last);

    // ****************************************
    // Bus address decode
    // ****************************************
    wire hit_ctrl  = avs_address == `RIE_OFS_CTRL;
    wire hit_instr = avs_address == `RIE_OFS_INSTR;
    wire hit_stat  = avs_address == `RIE_OFS_STATUS;
    wire hit_acc   = avs_address == `RIE_OFS_ACC;
    wire hit_pma   = avs_address == `RIE_OFS_PMADDR;
    wire hit_pmd   = avs_address == `RIE_OFS_PMDATA;
    wire hit_id    = (avs_address >= `RIE_OFS_ID0) & (avs_address <= `RIE_OFS_ID3)
                     & (avs_address[1:0] == 2'b00);
    wire hit_file  = (avs_address[9:7] == `RIE_FILE_SEL) & (avs_address[1:0] == 2'b00);
    wire [1:0] id_idx   = avs_address[3:2];
    wire [4:0] file_idx = avs_address[6:2];

    // Request handshake
    wire req       = (avs_read | avs_write) & wait_q;
    wire idle_ok   = state_q != RIE_ST_EXEC;
    // Core state may only be touched between instructions
    wire need_idle = hit_file | (avs_write & (hit_instr | hit_stat | hit_acc));
    wire file_rd   = avs_read & hit_file;
    wire accept    = req & (~need_idle | idle_ok) & (~file_rd | frd_q);
    wire frd_d     = req & file_rd & idle_ok & ~frd_q;
    wire wr_acc    = accept & avs_write;
    // Instruction starts only when awake and not in program mode
    wire start     = wr_acc & hit_instr & (state_q == RIE_ST_IDLE) & ~prog_q;  // RULE16
    wire wake      = wr_acc & hit_ctrl & avs_writedata[`RIE_CTRL_WAKE]
                     & (state_q == RIE_ST_SLEEP);

    // Verify readout, blanked when protected or outside program mode
    wire [11:0] pm_view = (prog_q & ~code_protect_in) ? pm_data_in : 12'h000;  // RULE15
    // ID words are invisible during normal execution
    wire [11:0] id_view = prog_q ? id_q[id_idx] : 12'h000;                    // RULE16

    // Read data select
    wire [31:0] rd_val =
        hit_ctrl  ? {31'h0, prog_q} :
        hit_instr ? {20'h0, instr_q} :
        hit_stat  ? {24'h0, sleep_q, (state_q == RIE_ST_EXEC), pin_change_wake_flag_q, to_q, pd_q,
                     z_q, dc_q, c_q} :
        hit_acc   ? {24'h0, acc_q} :
        hit_pma   ? {23'h0, pm_addr_q} :
        hit_pmd   ? {20'h0, pm_view} :
        hit_id    ? {20'h0, id_view} :
        hit_file  ? {24'h0, rf.rdata} :
        `RIE_RD_ZERO;

    // ****************************************
    // File array port muxing
    // ****************************************
    // The core owns the port while executing, the bus otherwise
    assign rf.raddr = (state_q == RIE_ST_EXEC) ? f_fld : file_idx;
    assign rf.we    = (commit & to_file) | (wr_acc & hit_file);      // RULE2
    assign rf.waddr = commit ? f_fld : file_idx;
    assign rf.wdata = commit ? res : avs_writedata[7:0];

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RIE_ST_IDLE:
            begin
                if (start)
                begin
                    state_d = RIE_ST_EXEC;
                end
            end
            RIE_ST_EXEC:
            begin
                // Sleep halts after its own cycle ends
                if (ph_end)
                begin
                    state_d = op_sleep ? RIE_ST_SLEEP : RIE_ST_IDLE;   // RULE13
                end
            end
            RIE_ST_SLEEP:
            begin
                if (wake)
                begin
                    state_d = RIE_ST_IDLE;
                end
            end
            default:
            begin
                state_d = RIE_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // State and phase counter
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= RIE_ST_IDLE;
            ph_q    <= 3'h0;
            sleep_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ph_q    <= (state_q == RIE_ST_EXEC) ? ph_q + 3'h1 : 3'h0;  // RULE7
            sleep_q <= state_d == RIE_ST_SLEEP;
        end
    end

    // Instruction latch and cycle length
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            instr_q <= `RIE_INSTR_RST;
            two_q   <= 1'b0;
        end
        else if (start)
        begin
            instr_q <= avs_writedata[11:0];   // RULE1
            two_q   <= 1'b0;
        end
        else if (commit)
        begin
            two_q   <= pc_write;              // RULE8
        end
    end

    // ****************************************
    // Accumulator and flags
    // ****************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            acc_q <= `RIE_ACC_RST;
            c_q   <= `RIE_FLAG_RST;
            dc_q  <= `RIE_FLAG_RST;
            z_q   <= `RIE_FLAG_RST;
        end
        else if (commit)
        begin
            if (to_acc)
            begin
                acc_q <= res;                 // RULE2
            end
            if (sets_c)
            begin
                c_q  <= new_c;                // RULE9 RULE14 RULE18
                dc_q <= new_dc;               // RULE9 RULE14
            end
            if (sets_z)
            begin
                z_q <= new_z;                 // RULE19
            end
        end
        else if (wr_acc & hit_acc)
        begin
            acc_q <= avs_writedata[7:0];
        end
        else if (wr_acc & hit_stat)
        begin
            // Software may preset arithmetic flags between instructions
            c_q  <= avs_writedata[`RIE_ST_C];
            dc_q <= avs_writedata[`RIE_ST_DC];
            z_q  <= avs_writedata[`RIE_ST_Z];
        end
    end

    // Power flags and watchdog clear pulse
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            to_q      <= `RIE_TO_RST;
            pd_q      <= `RIE_PD_RST;
            pin_change_wake_flag_q   <= `RIE_PIN_CHANGE_WAKE_FLAG_RST;
            wdt_clr_q <= 1'b0;
        end
        else
        begin
            wdt_clr_q <= commit & op_sleep;   // RULE13
            if (commit & op_sleep)
            begin
                to_q    <= 1'b1;              // RULE13
                pd_q    <= 1'b0;              // RULE13
                pin_change_wake_flag_q <= 1'b1;              // RULE13
            end
        end
    end

    // ****************************************
    // Program mode, verify and ID words
    // ****************************************
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            prog_q    <= 1'b0;
            pm_addr_q <= `RIE_PMADDR_RST;
            for (int i = 0; i < 4; i++)
            begin
                id_q[i] <= `RIE_ID_RST;
            end
        end
        else
        begin
            if (wr_acc & hit_ctrl)
            begin
                prog_q <= avs_writedata[`RIE_CTRL_PROG];
            end
            if (wr_acc & hit_pma)
            begin
                pm_addr_q <= avs_writedata[8:0];
            end
            // Full 12 bits stored; upper ones are the programmer's duty
            if (wr_acc & hit_id & prog_q)
            begin
                id_q[id_idx] <= avs_writedata[11:0];  // RULE16 RULE17
            end
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // Waitrequest drops for exactly the taking cycle
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            wait_q  <= 1'b1;
            rdata_q <= `RIE_RD_ZERO;
            frd_q   <= 1'b0;
        end
        else
        begin
            wait_q <= ~accept;
            frd_q  <= frd_d;
            if (accept & avs_read)
            begin
                rdata_q <= rd_val;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pm_addr_out     = pm_addr_q;
    assign wdt_clear_out   = wdt_clr_q;
    assign sleep_out       = sleep_q;

endmodule : rie_core

// ---- verification/rie_core_sva.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checks for the execute block
// ****************************************
module rie_core_sva
(
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        reset_in,
    // Register bus
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Verify path and power
    input wire logic [11:0] pm_data_in,
    input wire logic        code_protect_in,
    input wire logic [8:0]  pm_addr_out,
    input wire logic        wdt_clear_out,
    input wire logic        sleep_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // Transfers as the master sees them taken
    wire logic        wr_take = avs_write && !avs_waitrequest;
    wire logic        rd_take = avs_read && !avs_waitrequest;
    wire logic [11:0] wd_low  = avs_writedata[11:0];
    wire logic        wake    = wr_take && avs_address == 10'h000 && avs_writedata[1];

    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("answer without a request");
    a_wdt_cause: assert property ($rose(wdt_clear_out) |-> !$past(avs_waitrequest, 2) &&
        $past(avs_address, 2) == 10'h004 && $past(wd_low, 2) == 12'h003)
        else $error("watchdog clear without a sleep instruction");
    a_wdt_single: assert property (wdt_clear_out |=> !wdt_clear_out)
        else $error("watchdog clear longer than one cycle");
    a_sleep_entry: assert property ($rose(wdt_clear_out) |-> ##2 sleep_out)
        else $error("halt did not follow watchdog clear");
    // The halt ends in the very cycle the wake write is answered
    a_sleep_hold: assert property (sleep_out |=> sleep_out || wake)
        else $error("halt left without a wake write");
    a_sleep_wake: assert property (wake |-> !sleep_out)
        else $error("wake write did not end the halt");
    a_pm_load: assert property (wr_take && avs_address == 10'h010 |=>
        {3'h0, pm_addr_out} == $past(wd_low))
        else $error("verify address not loaded");
    a_pm_protect: assert property (rd_take && avs_address == 10'h014 && code_protect_in
        |-> avs_readdata == 32'h0000_0000)
        else $error("protected program word visible");
    a_unmapped: assert property (rd_take && avs_address >= 10'h100 |->
        avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : rie_core_sva

bind rie_core rie_core_sva i_rie_core_sva (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pm_data_in(pm_data_in),
    .code_protect_in(code_protect_in), .pm_addr_out(pm_addr_out),
    .wdt_clear_out(wdt_clear_out), .sleep_out(sleep_out));

// ---- verification/risc12_instruction_execute_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for the execute block
// ****************************************
module risc12_instruction_execute_tb;
    logic        core_clk_in;     // 100 MHz
    logic        reset_in;        // Synchronous, high
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] pm_data_in;
    logic        code_protect_in;
    logic [8:0]  pm_addr_out;
    logic        wdt_clear_out;
    logic        sleep_out;
    int          err_count;       // Mismatches
    int          comparisons;     // Compares made
    int          cyc;             // Clock count, also the hang limit
    int          wdt_pulses;      // Watchdog clear pulses seen
    int          dt_a;
    int          dt_b;
    logic [31:0] rd;
    logic [4:0]  fi;
    // Instruction, acc, file, flags before; acc, file, flags after
    logic [51:0] tbl [10] = '{52'h1c5_17_c2_0_d9_c2_0, 52'h1e5_ff_01_0_ff_00_7,
        52'he5f_a3_55_3_03_55_3, 52'h165_17_c2_3_17_02_3, 52'he00_a3_5a_0_00_5a_4,
        52'h4e5_00_c7_7_00_47_7, 52'h41f_00_ff_0_00_fe_0, 52'h0a5_02_03_0_02_01_3,
        52'h085_02_02_0_00_02_7, 52'h0bf_02_01_7_02_ff_0};

    rie_core i_rie_core (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pm_data_in(pm_data_in),
        .code_protect_in(code_protect_in), .pm_addr_out(pm_addr_out),
        .wdt_clear_out(wdt_clear_out), .sleep_out(sleep_out));

    // Clock
    initial core_clk_in = 1'b0;
    always #5 core_clk_in = ~core_clk_in;

    // Cycle count, pulse count and hang limit
    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        if (wdt_clear_out === 1'b1) wdt_pulses <= wdt_pulses + 1;
        if (cyc > 20000)
        begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    // Compare one value
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Bus write, held until waitrequest is sampled low
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge core_clk_in); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus_wr

    // Bus read, data taken at the answering edge
    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge core_clk_in); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus_rd

    // Time from an instruction to the next accepted accumulator write
    task automatic timed(input logic [11:0] ins, output int dt);
        int t;
        bus_wr(10'h004, {20'h0, ins});
        t = cyc;
        bus_wr(10'h00c, 32'h0);
        dt = cyc - t;
    endtask : timed

    // Verdict
    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial
    begin
        {reset_in, avs_address, avs_read, avs_write, avs_writedata} = {1'b1, 44'h0};
        {pm_data_in, code_protect_in, cyc, wdt_pulses} = {12'hab3, 1'b0, 64'h0};
        {err_count, comparisons} = 64'h0;
        repeat (10) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        bus_rd(10'h008, rd);
        check("status reset", rd, 32'h38);
        // Operation table
        foreach (tbl[i])
        begin
            fi = tbl[i][44:40];
            bus_wr(10'h00c, {24'h0, tbl[i][39:32]});
            bus_wr(10'h080 + {3'h0, fi, 2'h0}, {24'h0, tbl[i][31:24]});
            bus_wr(10'h008, {28'h0, tbl[i][23:20]});
            bus_wr(10'h004, {20'h0, tbl[i][51:40]});
            bus_rd(10'h080 + {3'h0, fi, 2'h0}, rd);
            check("file", rd, {24'h0, tbl[i][11:4]});
            bus_rd(10'h00c, rd);
            check("acc", rd, {24'h0, tbl[i][19:12]});
            bus_rd(10'h008, rd);
            check("status", rd, 32'h38 | {29'h0, tbl[i][2:0]});
        end
        // Extra instruction cycle when the result lands in the program counter
        // File 2 is never reset, so give it a value before adding into it
        bus_wr(10'h088, 32'h1);
        timed(12'h1c5, dt_a);
        timed(12'h1e2, dt_b);
        check("pc stretch", dt_b - dt_a, 32'h4);
        // Halt, refusal while halted, wake
        bus_wr(10'h004, 32'h003);
        repeat (6) @(posedge core_clk_in);
        check("halted", {31'h0, sleep_out}, 32'h1);
        check("wdt pulses", wdt_pulses, 32'h1);
        bus_rd(10'h008, rd);
        check("status halt", rd, 32'hb0);
        bus_wr(10'h00c, 32'h5a);
        bus_wr(10'h004, 32'he0f);
        bus_rd(10'h00c, rd);
        check("acc halted", rd, 32'h5a);
        bus_wr(10'h000, 32'h2);
        check("woken", {31'h0, sleep_out}, 32'h0);
        // Identity words and verify readout
        bus_wr(10'h020, 32'h5a5);
        bus_rd(10'h020, rd);
        check("id hidden", rd, 32'h0);
        bus_wr(10'h000, 32'h1);
        bus_rd(10'h02c, rd);
        check("id3 reset", rd, 32'hfff);
        bus_wr(10'h020, 32'hff5);
        bus_rd(10'h020, rd);
        check("id0", rd, 32'hff5);
        bus_wr(10'h010, 32'h1a5);
        check("pm addr", {23'h0, pm_addr_out}, 32'h1a5);
        bus_rd(10'h014, rd);
        check("pm open", rd, 32'hab3);
        code_protect_in <= 1'b1;
        bus_rd(10'h014, rd);
        check("pm locked", rd, 32'h0);
        bus_rd(10'h3f0, rd);
        check("unmapped", rd, 32'h0);
        tally_and_finish();
    end
endmodule : risc12_instruction_execute_tb
